// ### hdl/mas_port_map.svh
// Register offsets, field positions, reset values and counts of the serial audio port
`ifndef MAS_PORT_MAP_SVH
`define MAS_PORT_MAP_SVH
// ****************************************************************
// Register indices and reset values
// ****************************************************************
`define MAS_FMT_REG_IDX     4'h4
`define MAS_CMP_REG_IDX     4'h5
`define MAS_CLK_REG_IDX     4'h6
`define MAS_FMT_REG_RST     10'h050
`define MAS_CMP_REG_RST     9'h000
`define MAS_CLK_REG_RST     9'h000
// ****************************************************************
// Field positions
// ****************************************************************
`define MAS_MONO_BIT        9
`define MAS_SCP_BIT         8
`define MAS_ACP_BIT         7
`define MAS_WL_HI           6
`define MAS_WL_LO           5
`define MAS_FMT_HI          4
`define MAS_FMT_LO          3
`define MAS_SWAP_BIT        1
`define MAS_WL8_BIT         5
`define MAS_DIV_HI          4
`define MAS_DIV_LO          2
`define MAS_MS_BIT          0
// ****************************************************************
// Word lengths, frame geometry and the largest divider code
// ****************************************************************
`define MAS_LEN_8           6'h08
`define MAS_LEN_16          6'h10
`define MAS_LEN_20          6'h14
`define MAS_LEN_24          6'h18
`define MAS_LEN_32          6'h20
`define MAS_HALF_BITS       6'h20
`define MAS_DIV_MAX         3'h5
`endif

// ### hdl/mas_port_pkg.sv
// Types shared by the serial audio port files
package mas_port_pkg;
  typedef enum logic [1:0] {
    MAS_FMT_RJ  = 2'h0,
    MAS_FMT_LJ  = 2'h1,
    MAS_FMT_I2S = 2'h2,
    MAS_FMT_DSP = 2'h3
  } mas_fmt_e;

  typedef enum logic [2:0] {
    MAS_ST_IDLE = 3'b001,
    MAS_ST_RUN  = 3'b010,
    MAS_ST_HOLD = 3'b100
  } mas_state_e;

  // Clock divider state
  typedef struct packed {
    logic [4:0] cnt;
    logic       level;
  } mas_div_s;

  // Serial engine state
  typedef struct packed {
    mas_state_e  st;
    logic [9:0]  fmt_reg;
    logic [8:0]  cmp_reg;
    logic [8:0]  clk_reg;
    logic [8:0]  rdata;
    logic        bclk_prev;
    logic        frame_prev;
    logic [6:0]  bitpos;
    logic        phase;
    logic [31:0] shreg;
    logic [31:0] held;
    logic        sdo;
    logic        bclk_o;
    logic        frame_o;
    logic [6:0]  half_cnt;
  } mas_eng_s;
endpackage

// ### hdl/mas_clk_div.sv
// Divider that makes the master-mode bit clock level from the system clock
`timescale 1ns/1ps
module mas_clk_div #(
  parameter int CW = 5
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  output logic            bclk_level,
  output logic            rise_pulse,
  output logic            fall_pulse
);
  mas_port_pkg::mas_div_s div_reg;
  mas_port_pkg::mas_div_s div_next;
  logic [CW-1:0]          half;
  logic                   wrap;

  // Level lasts 2**code system clocks, so each code step doubles the period
  always_comb begin
    half = CW'((1 << div_code) - 1);
    wrap = (div_reg.cnt >= half);
    div_next = div_reg;
    if (!run) begin
      div_next.cnt   = '0;
      div_next.level = 1'b0;
    end else if (wrap) begin
      div_next.cnt   = '0;
      div_next.level = ~div_reg.level;
    end else begin
      div_next.cnt = div_reg.cnt + CW'(1);
    end
  end

  // Divider state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign bclk_level = div_reg.level;
  assign rise_pulse = run & wrap & ~div_reg.level;
  assign fall_pulse = run & wrap & div_reg.level;
endmodule // mas_clk_div

// ### hdl/mas_port.sv
// Serial audio output port of a mono converter: registers, clocks and shifter
`timescale 1ns/1ps
`include "mas_port_map.svh"
module mas_port #(
  parameter int SW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          reg_wr,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [9:0]    reg_wdata,
  output logic      [9:0]    reg_rdata,
  input  wire logic [SW-1:0] sample_in,
  input  wire logic          sample_valid,
  input  wire logic          bclk_in,
  input  wire logic          frame_in,
  output logic               bclk_out,
  output logic               bclk_oe,
  output logic               frame_out,
  output logic               frame_oe,
  output logic               serial_sample_out
);
  mas_port_pkg::mas_eng_s r_reg;
  mas_port_pkg::mas_eng_s r_next;
  mas_port_pkg::mas_fmt_e data_format_select;
  logic       master_select;
  logic [2:0] bitclk_divider;
  logic       align_clock_polarity;
  logic       shift_clock_polarity;
  logic       mono_both_channels;
  logic       channel_phase_swap;
  logic       byte_word_length_override;
  logic [1:0] sample_word_length;
  logic [5:0] wlen;
  logic       div_bclk;
  logic       div_rise;
  logic       div_fall;
  logic       bclk_eff;
  logic       frame_eff;
  logic       rise;
  logic       fall;
  logic       frame_edge;
  logic       frame_rise;
  logic       right_ph;
  logic        want;
  logic [6:0]  lead;
  logic [6:0]  idx;
  logic        active;
  logic        frame_wrap;
  logic        frame_now;
  logic        start;
  logic [6:0]  pos;
  logic [6:0]  span;
  logic        live;
  logic        reload;
  logic [31:0] sh_cur;

  // ****************************************************************
  // Register fields
  // ****************************************************************
  assign mono_both_channels        = r_reg.fmt_reg[`MAS_MONO_BIT];
  assign shift_clock_polarity      = r_reg.fmt_reg[`MAS_SCP_BIT];
  assign align_clock_polarity      = r_reg.fmt_reg[`MAS_ACP_BIT];
  assign sample_word_length        = r_reg.fmt_reg[`MAS_WL_HI:`MAS_WL_LO];
  assign data_format_select        = mas_port_pkg::mas_fmt_e'(r_reg.fmt_reg[`MAS_FMT_HI:`MAS_FMT_LO]);
  assign channel_phase_swap        = r_reg.fmt_reg[`MAS_SWAP_BIT];
  assign byte_word_length_override = r_reg.cmp_reg[`MAS_WL8_BIT];
  assign bitclk_divider            = r_reg.clk_reg[`MAS_DIV_HI:`MAS_DIV_LO];
  assign master_select             = r_reg.clk_reg[`MAS_MS_BIT];

  // Word length; the byte override wins, right justified stops at 24
  always_comb begin
    unique case (sample_word_length)
      2'h0:    wlen = `MAS_LEN_16;
      2'h1:    wlen = `MAS_LEN_20;
      2'h2:    wlen = `MAS_LEN_24;
      default: wlen = (data_format_select == mas_port_pkg::MAS_FMT_RJ) ? `MAS_LEN_24 : `MAS_LEN_32;
    endcase
    if (byte_word_length_override) begin
      wlen = `MAS_LEN_8;
    end
  end

  // ****************************************************************
  // Master clock divider
  // ****************************************************************
  mas_clk_div #(
    .CW(5)
  ) u_div (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .run        (master_select),
    .div_code   ((bitclk_divider > `MAS_DIV_MAX) ? `MAS_DIV_MAX : bitclk_divider),
    .bclk_level (div_bclk),
    .rise_pulse (div_rise),
    .fall_pulse (div_fall)
  );

  // Clock source pick; inputs are taken as synchronous to sys_clk
  always_comb begin
    if (master_select) begin
      bclk_eff  = div_bclk;
      frame_eff = r_reg.frame_o;
      rise      = div_rise;
      fall      = div_fall;
    end else begin
      bclk_eff  = bclk_in ^ shift_clock_polarity;
      frame_eff = frame_in;
      rise      = bclk_eff & ~r_reg.bclk_prev;
      fall      = ~bclk_eff & r_reg.bclk_prev;
    end
  end

  // Master frame toggle folded in at once, so it lines up with its own bit clock fall
  assign frame_wrap = master_select && fall &&
                      (r_reg.half_cnt == 7'(`MAS_HALF_BITS) - 7'h1);
  assign frame_now  = frame_eff ^ frame_wrap;
  // Frame edges taken with the falling bit clock, so slot 0 is ready for the first rise
  assign frame_edge = fall & (frame_now != r_reg.frame_prev);
  assign frame_rise = fall & frame_now & ~r_reg.frame_prev;
  assign start      = (data_format_select == mas_port_pkg::MAS_FMT_DSP) ? frame_rise : frame_edge;
  assign pos        = start ? 7'h0 : ((r_reg.bitpos == 7'h7f) ? 7'h7f : r_reg.bitpos + 7'h1);

  // Bits of delay from the frame edge to the MSB
  always_comb begin
    unique case (data_format_select)
      mas_port_pkg::MAS_FMT_LJ:  lead = 7'h0;
      mas_port_pkg::MAS_FMT_I2S: lead = 7'h1;
      mas_port_pkg::MAS_FMT_DSP: lead = align_clock_polarity ? 7'h0 : 7'h1;
      default:                   lead = 7'(`MAS_HALF_BITS) - 7'(wlen);
    endcase
  end
  // DSP carries both words back to back in one span
  assign idx    = pos - lead;
  assign span   = (data_format_select == mas_port_pkg::MAS_FMT_DSP) ? 7'(wlen) + 7'(wlen) : 7'(wlen);
  assign active = (pos >= lead) && (idx < span);
  // Frame high is left except in I2S; polarity inverts outside DSP
  assign right_ph = (data_format_select == mas_port_pkg::MAS_FMT_DSP) ? (idx >= 7'(wlen))
                  : (~frame_now ^ align_clock_polarity ^
                     (data_format_select == mas_port_pkg::MAS_FMT_I2S));
  // Channel that carries data: left unless swapped, mono fills both
  assign want   = mono_both_channels | (right_ph == channel_phase_swap);
  assign live   = start | (r_reg.st != mas_port_pkg::MAS_ST_IDLE);
  assign reload = start | ((data_format_select == mas_port_pkg::MAS_FMT_DSP) && idx == 7'(wlen));
  assign sh_cur = reload ? (r_reg.held << (7'(`MAS_LEN_32) - 7'(wlen))) : r_reg.shreg;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    r_next.bclk_prev = bclk_eff;
    // Register writes; reads return the addressed register, but bit 9 of the format register reads as zero
    if (reg_wr) begin
      unique case (reg_addr)
        `MAS_FMT_REG_IDX: r_next.fmt_reg = reg_wdata;
        `MAS_CMP_REG_IDX: r_next.cmp_reg = reg_wdata[8:0];
        `MAS_CLK_REG_IDX: r_next.clk_reg = reg_wdata[8:0];
        default: ;
      endcase
    end
    unique case (reg_addr)
      `MAS_FMT_REG_IDX: r_next.rdata = r_reg.fmt_reg[8:0];
      `MAS_CMP_REG_IDX: r_next.rdata = r_reg.cmp_reg;
      `MAS_CLK_REG_IDX: r_next.rdata = r_reg.clk_reg;
      default:          r_next.rdata = 9'h000;
    endcase
    if (sample_valid) begin
      r_next.held = 32'(sample_in);
    end
    // Master frame: one level per 32 bit clocks, changed on the falling edge
    if (master_select && fall) begin
      if (frame_wrap) begin
        r_next.half_cnt = 7'h0;
        r_next.frame_o  = ~r_reg.frame_o;
      end else begin
        r_next.half_cnt = r_reg.half_cnt + 7'h1;
      end
    end
    // Data changes on the falling edge so it is steady at the rising one
    if (fall) begin
      r_next.frame_prev = frame_now;
      r_next.bitpos     = pos;
      r_next.phase      = want;
      if (start) begin
        r_next.st = mas_port_pkg::MAS_ST_RUN;
      end
      if (live && want && active) begin
        r_next.sdo = sh_cur[31];
      end else begin
        r_next.sdo = 1'b0;
      end
      r_next.shreg = active ? {sh_cur[30:0], 1'b0} : sh_cur;
    end
    r_next.bclk_o = div_bclk ^ shift_clock_polarity;
  end

  // Registered state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg         <= '0;
      r_reg.st      <= mas_port_pkg::MAS_ST_IDLE;
      r_reg.fmt_reg <= `MAS_FMT_REG_RST;
      r_reg.cmp_reg <= `MAS_CMP_REG_RST;
      r_reg.clk_reg <= `MAS_CLK_REG_RST;
      r_reg.bitpos  <= 7'h7f;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops except frame_out, whose polarity is applied after its flop
  // ****************************************************************
  assign reg_rdata         = {1'b0, r_reg.rdata};
  assign serial_sample_out = r_reg.sdo;
  assign bclk_out          = r_reg.bclk_o;
  assign frame_out         = r_reg.frame_o ^ (align_clock_polarity &
                             (data_format_select != mas_port_pkg::MAS_FMT_DSP)) ^ 1'b0;
  assign bclk_oe           = r_reg.clk_reg[`MAS_MS_BIT];
  assign frame_oe          = r_reg.clk_reg[`MAS_MS_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ms_reset;
    @(posedge sys_clk) $rose(rst_n) |-> !bclk_oe && !frame_oe;
  endproperty
  a_ms_reset: assert property (p_ms_reset) else $error("clocks not inputs after reset");

  property p_oe_follow;
    @(posedge sys_clk) disable iff (!rst_n) reg_wr && reg_addr == `MAS_CLK_REG_IDX
      |=> bclk_oe == $past(reg_wdata[0]) && frame_oe == bclk_oe;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("master select write not applied");

  property p_data_on_fall;
    @(posedge sys_clk) disable iff (!rst_n) !$past(fall) |-> $stable(serial_sample_out);
  endproperty
  a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off falling edge");

  property p_idle_low;
    @(posedge sys_clk) disable iff (!rst_n) fall && !(live && want && active) |=> !serial_sample_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle bit not driven low");

  property p_msb_first;
    @(posedge sys_clk) disable iff (!rst_n) fall && active && want && live
      |=> serial_sample_out == $past(sh_cur[31]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit not taken from top");

  property p_wl8;
    @(posedge sys_clk) disable iff (!rst_n) byte_word_length_override |-> wlen == `MAS_LEN_8;
  endproperty
  a_wl8: assert property (p_wl8) else $error("byte override ignored");

  property p_rj24;
    @(posedge sys_clk) disable iff (!rst_n) data_format_select == mas_port_pkg::MAS_FMT_RJ |-> wlen <= `MAS_LEN_24;
  endproperty
  a_rj24: assert property (p_rj24) else $error("right justified word over 24");

  property p_lead;
    @(posedge sys_clk) disable iff (!rst_n) data_format_select == mas_port_pkg::MAS_FMT_I2S |-> lead == 7'h1;
  endproperty
  a_lead: assert property (p_lead) else $error("i2s delay wrong");

  c_master: cover property (@(posedge sys_clk) disable iff (!rst_n) master_select && frame_edge);
  c_dsp:    cover property (@(posedge sys_clk) disable iff (!rst_n)
                            data_format_select == mas_port_pkg::MAS_FMT_DSP && frame_rise);
  c_data:   cover property (@(posedge sys_clk) disable iff (!rst_n) fall && active && want);
  c_rise:   cover property (@(posedge sys_clk) disable iff (!rst_n) rise && serial_sample_out);
endmodule // mas_port

// ### bench/mas_host_model.sv
// Host serial port model: makes the slave clocks and captures each frame
`timescale 1ns/1ps
module mas_host_model (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  input  wire logic   run,
  input  wire logic   dsp,
  input  wire logic   sdo,
  output logic        bclk,
  output logic        frame,
  output logic [63:0] frame_word,
  output int          nframes
);
  logic [1:0]  ph;
  logic [5:0]  cnt;
  logic [5:0]  nxt;
  logic [63:0] work;
  assign nxt = cnt + 6'h01;
  // Half period of four system clocks, since the port needs two per level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph         <= 2'h0;
      cnt        <= 6'h3f;
      bclk       <= 1'b0;
      frame      <= 1'b0;
      work       <= 64'h0;
      frame_word <= 64'h0;
      nframes    <= 0;
    end else if (run) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        bclk <= ~bclk;
        if (bclk) begin
          // Falling edge: next slot, frame moves with it
          cnt   <= nxt;
          frame <= dsp ? (nxt == 6'h00) : ~nxt[5];
        end else begin
          // Rising edge: every slot kept, the bench decides what idle ones mean
          work[cnt] <= sdo;
          if (cnt == 6'h3f) begin
            frame_word <= {sdo, work[62:0]};
            nframes    <= nframes + 1;
          end
        end
      end
    end
  end
endmodule // mas_host_model

// ### bench/mas_port_tb.sv
// Self-checking bench for the serial audio port
`timescale 1ns/1ps
`include "mas_port_map.svh"
module mas_port_tb;
  localparam logic [31:0] SMP = 32'hc5a396e1;
  logic        sys_clk;
  logic        rst_n;
  logic        reg_wr;
  logic [3:0]  reg_addr;
  logic [9:0]  reg_wdata;
  logic [9:0]  reg_rdata;
  logic [31:0] sample_in;
  logic        sample_valid;
  logic        bclk_in;
  logic        frame_in;
  logic        bclk_out;
  logic        bclk_oe;
  logic        frame_out;
  logic        frame_oe;
  logic        sdo;
  logic        host_run;
  logic        host_dsp;
  logic [63:0] frame_word;
  int          nframes;
  int          num_errors;
  int          comparisons;
  int          cycles = 0;

  mas_port #(.SW(32)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_in(sample_in),
    .sample_valid(sample_valid), .bclk_in(bclk_in), .frame_in(frame_in),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .frame_out(frame_out),
    .frame_oe(frame_oe), .serial_sample_out(sdo)
  );
  mas_host_model u_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .run(host_run), .dsp(host_dsp), .sdo(sdo),
    .bclk(bclk_in), .frame(frame_in), .frame_word(frame_word), .nframes(nframes)
  );

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Whole run is near 24000 cycles; two and a half times that means a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [9:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({54'h0, reg_rdata}, {54'h0, e}, "register read");
  endtask
  // Expected capture of one frame, slot 0 is the first rise after the frame edge
  function automatic logic [63:0] exp_word(input logic [1:0] f, input logic acp, input logic swap,
                                           input logic mono, input int len);
    logic [63:0] w;
    int          off;
    int          c;
    int          i;
    w = 64'h0;
    for (c = 0; c < 2; c++) begin
      if (mono || c == int'(swap)) begin
        // Left half is frame high except in I2S; polarity swaps halves outside DSP
        if (f == 2'h3) off = (acp ? 0 : 1) + c * len;
        else off = 32 * (c ^ int'(f == 2'h2) ^ int'(acp)) + (f == 2'h0 ? 32 - len : int'(f == 2'h2));
        for (i = 0; i < len; i++) w[off + i] = SMP[len - 1 - i];
      end
    end
    return w;
  endfunction
  // Configure, load one sample, let the setting settle for two frames, judge the third
  task automatic run_fmt(input logic [9:0] fv, input logic [8:0] cv, input int len, input string name);
    int          n0;
    int          n;
    logic [63:0] e;
    e = exp_word(fv[`MAS_FMT_HI:`MAS_FMT_LO], fv[`MAS_ACP_BIT], fv[`MAS_SWAP_BIT], fv[`MAS_MONO_BIT], len);
    wr(`MAS_FMT_REG_IDX, fv);
    host_dsp <= (fv[`MAS_FMT_HI:`MAS_FMT_LO] == 2'h3);
    host_run <= 1'b1;
    wr(`MAS_CMP_REG_IDX, {1'b0, cv});
    sample_in    <= SMP;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    n0 = nframes;
    n  = 0;
    while (nframes < n0 + 3 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    #1;
    chk(frame_word, e, name);
    $display("TEST %s done", name);
  endtask
  // Cycles between the second and third rise of a master clock
  task automatic meas(input logic fr, output int p);
    int   n;
    int   r;
    int   t0;
    logic pv;
    logic v;
    n  = 0;
    r  = 0;
    t0 = 0;
    p  = 0;
    pv = 1'b1;
    while (r < 3 && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
      v = fr ? frame_out : bclk_out;
      if (v === 1'b1 && pv === 1'b0) begin
        r++;
        if (r == 2) t0 = n;
        if (r == 3) p = n - t0;
      end
      pv = v;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    chk({62'h0, bclk_oe, frame_oe}, 64'h0, "clocks are inputs after reset");
    rd_chk(`MAS_FMT_REG_IDX, `MAS_FMT_REG_RST);
    rd_chk(`MAS_CMP_REG_IDX, {1'b0, `MAS_CMP_REG_RST});
    rd_chk(`MAS_CLK_REG_IDX, {1'b0, `MAS_CLK_REG_RST});
    wr(`MAS_FMT_REG_IDX, 10'h3fa);
    wr(4'h3, 10'h155);
    rd_chk(`MAS_FMT_REG_IDX, 10'h1fa);
    rd_chk(4'h3, 10'h000);
    $display("TEST registers done");
  endtask
  task automatic t_lj24();
    run_fmt(10'h048, 9'h000, 24, "left justified 24");
  endtask
  task automatic t_i2s16();
    run_fmt(10'h010, 9'h000, 16, "i2s 16");
  endtask
  task automatic t_rj32();
    run_fmt(10'h060, 9'h000, 24, "right justified 32 as 24");
  endtask
  task automatic t_rj20();
    run_fmt(10'h020, 9'h000, 20, "right justified 20");
  endtask
  task automatic t_dsp_a_mono();
    run_fmt(10'h218, 9'h000, 16, "dsp mode a mono");
  endtask
  task automatic t_dsp_b_swap();
    run_fmt(10'h09a, 9'h000, 16, "dsp mode b right");
  endtask
  task automatic t_byte_swap();
    run_fmt(10'h04a, 9'h020, 8, "byte override right");
  endtask
  task automatic t_i2s_inv();
    run_fmt(10'h0b0, 9'h000, 20, "i2s inverted frame");
  endtask
  task automatic t_master();
    int p3;
    int p4;
    int p7;
    int pf;
    wr(`MAS_CLK_REG_IDX, 10'h00d);
    host_run <= 1'b0;
    meas(1'b0, p3);
    chk({62'h0, bclk_oe, frame_oe}, 64'h3, "clocks driven in master");
    wr(`MAS_CLK_REG_IDX, 10'h011);
    meas(1'b0, p4);
    wr(`MAS_CLK_REG_IDX, 10'h01d);
    meas(1'b0, p7);
    meas(1'b1, pf);
    chk(64'(p4), 64'(2 * p3), "divider doubles per code");
    chk(64'(p7), 64'(4 * p3), "reserved code acts as largest");
    chk(64'(pf), 64'(64 * p7), "frame period in bit clocks");
    $display("TEST master clocks done");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n        = 1'b0;
    reg_wr       = 1'b0;
    reg_addr     = 4'h0;
    reg_wdata    = 10'h000;
    sample_in    = 32'h0;
    sample_valid = 1'b0;
    host_run     = 1'b0;
    host_dsp     = 1'b0;
    num_errors   = 0;
    comparisons  = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_regs();
    t_lj24();
    t_i2s16();
    t_rj32();
    t_rj20();
    t_dsp_a_mono();
    t_dsp_b_swap();
    t_byte_swap();
    t_i2s_inv();
    t_master();
    give_verdict();
  end
endmodule // mas_port_tb
